// ===== rtl/swt_pkg.sv
// Purpose: Shared constants for the self wake-up timer and its controller
// Assumes: One system clock, the 10 kHz oscillator arrives as a plain input
// Notes: Device registers sit at their byte addresses on the device port
package swt_pkg;

  // Device register addresses on the device port
  localparam logic [7:0] SWT_ADDR_RELOAD = 8'h86;
  localparam logic [7:0] SWT_ADDR_CTRL = 8'h8f;

  // Device register widths and reset values
  localparam int SWT_DATA_W = 8;
  localparam int SWT_CNT_W = 8;
  localparam int SWT_PS_CNT_W = 11;
  localparam logic [7:0] SWT_CTRL_RST = 8'h00;
  localparam logic [7:0] SWT_RELOAD_RST = 8'h00;
  localparam logic [7:0] SWT_CNT_MAX = 8'hff;

  // Control register field positions
  localparam int SWT_PS_LSB = 0;
  localparam int SWT_PS_MSB = 2;
  localparam int SWT_RUN_BIT = 3;
  localparam int SWT_FLAG_BIT = 4;
  localparam logic [2:0] SWT_RSVD_ZERO = 3'h0;
  localparam logic [2:0] SWT_PS_DIV1 = 3'h0;

  // Prescale select to oscillator divide ratio
  localparam int SWT_DIV [8] = '{1, 4, 16, 64, 256, 512, 1024, 2048};

  // Oscillator and system clock figures
  localparam int SWT_OSC_HZ = 10000;
  localparam int SWT_SYS_HZ = 10000000;

  // Controller register offsets on the APB side
  localparam logic [7:0] SWT_APB_CTRL = 8'h00;
  localparam logic [7:0] SWT_APB_RELOAD = 8'h04;
  localparam logic [7:0] SWT_APB_STAT = 8'h08;
  localparam logic [7:0] SWT_APB_IEN = 8'h0c;
  localparam logic [7:0] SWT_APB_ICLR = 8'h10;
  localparam logic [7:0] SWT_APB_MIRROR = 8'h14;
  localparam logic [7:0] SWT_APB_FCLR = 8'h18;

  // Controller control register fields
  localparam int SWT_H_WIEN_BIT = 4;
  localparam int SWT_H_GIEN_BIT = 5;
  localparam int SWT_H_OSCEN_BIT = 6;
  localparam int SWT_H_CTRL_W = 7;

  // Controller status bits: overflow seen, request refused
  localparam int SWT_ST_W = 2;
  localparam int SWT_ST_OVF = 0;
  localparam int SWT_ST_REF = 1;

endpackage

// ===== rtl/swt_if.sv
// Purpose: Register port between the wake-up timer and its controller
// Assumes: Both ends run on the same clock
// Notes: Controller drives requests, timer answers with registered data
`timescale 1ns/1ps
interface swt_if;
  import swt_pkg::*;

  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic [7:0] sfr_wdata;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  logic wakeup_irq_enable;
  logic global_irq_enable;

  // Timer end
  modport device(
    input sfr_addr,
    input sfr_wr,
    input sfr_wdata,
    input sfr_rd,
    input wakeup_irq_enable,
    input global_irq_enable,
    output sfr_rdata
  );

  // Controller end
  modport host(
    output sfr_addr,
    output sfr_wr,
    output sfr_wdata,
    output sfr_rd,
    output wakeup_irq_enable,
    output global_irq_enable,
    input sfr_rdata
  );

endinterface

// ===== rtl/swt_device.sv
// Purpose: Self wake-up timer, 8-bit auto-reload counter on a 10 kHz tick
// Assumes: System clock at least twice the oscillator rate
// Notes: Oscillator edges are found by sampling osc_in on the system clock
//
// What this block does
// RULE1: Periodic wake-up or plain general timer
// RULE2: Keeps counting in Idle and Power-down
// RULE3: Counts only on the 10 kHz oscillator
// RULE4: System clock at least twice oscillator
// RULE5: Oscillator held on once timer runs
// RULE6: Software enables oscillator, waits for stability
// RULE7: Software may start timer before sleeping
// RULE8: 8-bit up-counter with automatic reload
// RULE9: Prescale 1,4,16,64,256,512,1024,2048
// RULE10: Run bit high counts, low halts
// RULE11: Rollover sets flag and reloads counter
// RULE12: Flag with both enables raises interrupt
// RULE13: Flag stays set until software clears
// RULE14: Reload written only while halted
// RULE15: No reload FFH at divide by one
// RULE16: Control and reload reset to zero
// RULE17: Run, reload and overflow cross cleanly
// RULE18: Upper control bits read zero
`timescale 1ns/1ps
module swt_device
  import swt_pkg::*;
#(
  parameter int CNT_W = SWT_CNT_W,
  parameter int PS_W = SWT_PS_CNT_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_in,
  output logic osc_keep_on,
  output logic wake_irq,
  swt_if.device bus
);

  // Software visible state
  logic [2:0] ps_sel_r;
  logic run_r;
  logic flag_r;
  logic [CNT_W-1:0] reload_r;
  logic [7:0] rdata_r;

  // Oscillator side copies and counting state
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  logic run_osc_r;
  logic [2:0] ps_osc_r;
  logic [CNT_W-1:0] reload_osc_r;
  logic [PS_W-1:0] ps_cnt_r;
  logic [CNT_W-1:0] cnt_r;
  logic ovf_r;
  logic irq_r;
  logic keep_r;

  // Register decode
  wire hit_ctrl = (bus.sfr_addr == SWT_ADDR_CTRL);
  wire hit_reload = (bus.sfr_addr == SWT_ADDR_RELOAD);
  wire wr_ctrl = bus.sfr_wr & hit_ctrl;
  wire wr_reload = bus.sfr_wr & hit_reload;

  // Control word as software sees it
  // RULE18: reserved bits zero
  wire [7:0] ctrl_view = {SWT_RSVD_ZERO, flag_r, run_r, ps_sel_r};

  // Read data selection, unmapped reads zero
  wire [7:0] rd_word = hit_ctrl ? ctrl_view :
                       hit_reload ? reload_r : 8'h00;

  // Oscillator rising edge from the synchronised samples
  // RULE3: oscillator is sole clock
  wire osc_rise = osc_s2_r & ~osc_s3_r;

  // Divide ratio of the selected prescale, less one
  // RULE9: prescale divide table
  wire [PS_W-1:0] div_last = PS_W'(SWT_DIV[ps_osc_r] - 1);
  wire ps_wrap = (ps_cnt_r == div_last);

  // One counter step per prescaled tick while running
  // RULE10: run gates counting
  wire cnt_step = osc_rise & run_osc_r & ps_wrap;
  wire cnt_wrap = (cnt_r == SWT_CNT_MAX);

  // Flag next value, a rollover beats a clear in the same cycle
  // RULE13: only software clears flag
  wire flag_nxt = ovf_r ? 1'b1 :
                  (wr_ctrl & ~bus.sfr_wdata[SWT_FLAG_BIT]) ? 1'b0 : flag_r;

  // Oscillator input synchroniser, first stage read only by the second
  // RULE17: oscillator sampling chain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else if (ce) begin
      osc_s1_r <= osc_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Control register, writes from the controller
  // RULE16: zero after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ps_sel_r <= SWT_CTRL_RST[SWT_PS_MSB:SWT_PS_LSB];
      run_r <= SWT_CTRL_RST[SWT_RUN_BIT];
      flag_r <= SWT_CTRL_RST[SWT_FLAG_BIT];
    end else if (ce) begin
      if (wr_ctrl) begin
        ps_sel_r <= bus.sfr_wdata[SWT_PS_MSB:SWT_PS_LSB];
        run_r <= bus.sfr_wdata[SWT_RUN_BIT];
      end
      flag_r <= flag_nxt;
    end
  end

  // Reload byte; a write while running is taken but its effect is undefined
  // RULE14: halted-only reload writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reload_r <= SWT_RELOAD_RST;
    end else if (ce) begin
      if (wr_reload) begin
        reload_r <= bus.sfr_wdata;
      end
    end
  end

  // Registered read data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      if (bus.sfr_rd) begin
        rdata_r <= rd_word;
      end
    end
  end

  assign bus.sfr_rdata = rdata_r;

  // Settings taken over by the oscillator side on each rising oscillator edge
  // RULE17: run and reload crossing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_osc_r <= 1'b0;
      ps_osc_r <= SWT_CTRL_RST[SWT_PS_MSB:SWT_PS_LSB];
      reload_osc_r <= SWT_RELOAD_RST;
    end else if (ce) begin
      if (osc_rise) begin
        run_osc_r <= run_r;
        ps_osc_r <= ps_sel_r;
        reload_osc_r <= reload_r;
      end
    end
  end

  // Prescaler, cleared while halted
  // RULE9: prescaler count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ps_cnt_r <= '0;
    end else if (ce) begin
      if (!run_osc_r) begin
        ps_cnt_r <= '0;
      end else if (osc_rise) begin
        ps_cnt_r <= ps_wrap ? '0 : ps_cnt_r + 1'b1;
      end
    end
  end

  // Up-counter with reload; tracks the reload byte while halted.
  // Power modes are not looked at, so counting goes on through sleep.
  // RULE8: auto-reload up-counter
  // RULE2: counts through sleep
  // RULE1: free running timer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= SWT_RELOAD_RST;
    end else if (ce) begin
      if (!run_osc_r) begin
        cnt_r <= osc_rise ? reload_r : reload_osc_r; // Fresh reload on a starting edge
      end else if (cnt_step) begin
        // RULE11: reload on rollover
        cnt_r <= cnt_wrap ? reload_osc_r : cnt_r + 1'b1;
      end
    end
  end

  // Overflow pulse, handed to the flag one cycle later
  // RULE11: overflow sets flag
  // RULE17: overflow into flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_r <= 1'b0;
    end else if (ce) begin
      ovf_r <= cnt_step & cnt_wrap;
    end
  end

  // Interrupt request and oscillator hold
  // RULE12: both enables gate request
  // RULE5: keep oscillator running
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
      keep_r <= 1'b0;
    end else if (ce) begin
      irq_r <= flag_r & bus.wakeup_irq_enable & bus.global_irq_enable;
      keep_r <= run_r | run_osc_r;
    end
  end

  assign wake_irq = irq_r;
  assign osc_keep_on = keep_r;

endmodule

// ===== rtl/swt_host.sv
// Purpose: APB controller that programs the wake-up timer
// Assumes: Zero wait APB slave, registered pready high in the first access cycle
// Notes: Control register of the timer is polled every idle cycle
`timescale 1ns/1ps
module swt_host
  import swt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic osc_enable,
  input wire logic osc_stable,
  swt_if.host bus
);

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [SWT_H_CTRL_W-1:0] hctrl_r;
  logic [7:0] hreload_r;
  logic [SWT_ST_W-1:0] stat_r;
  logic [SWT_ST_W-1:0] ien_r;
  logic [7:0] mirror_r;
  logic rd_d_r;
  logic irq_r;
  logic sfr_wr_r;
  logic sfr_rd_r;
  logic [7:0] sfr_addr_r;
  logic [7:0] sfr_wdata_r;

  // APB phases and address decode
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pready_r & pwrite;
  wire hit_ctrl = (paddr == SWT_APB_CTRL);
  wire hit_reload = (paddr == SWT_APB_RELOAD);
  wire hit_stat = (paddr == SWT_APB_STAT);
  wire hit_ien = (paddr == SWT_APB_IEN);
  wire hit_iclr = (paddr == SWT_APB_ICLR);
  wire hit_mirror = (paddr == SWT_APB_MIRROR);
  wire hit_fclr = (paddr == SWT_APB_FCLR);
  wire mapped = hit_ctrl | hit_reload | hit_stat | hit_ien | hit_iclr | hit_mirror | hit_fclr;

  // Read data selection, write-only and unmapped read zero
  wire [31:0] rd_word = hit_ctrl ? 32'(hctrl_r) :
                        hit_reload ? 32'(hreload_r) :
                        hit_stat ? 32'(stat_r) :
                        hit_ien ? 32'(ien_r) :
                        hit_mirror ? 32'(mirror_r) : 32'h0;

  // RULE15: refuse reload FFH at divide by one
  wire bad_ctrl = (pwdata[SWT_PS_MSB:SWT_PS_LSB] == SWT_PS_DIV1) & (hreload_r == SWT_CNT_MAX);
  wire bad_rel = (hctrl_r[SWT_PS_MSB:SWT_PS_LSB] == SWT_PS_DIV1) & (pwdata[7:0] == SWT_CNT_MAX);
  // RULE14: reload only while halted
  wire rel_ok = wr_take & hit_reload & ~bad_rel & ~hctrl_r[SWT_RUN_BIT];
  wire ctl_ok = wr_take & hit_ctrl & ~bad_ctrl;
  wire fclr = wr_take & hit_fclr & pwdata[0];
  wire refused = wr_take & ((hit_reload & ~rel_ok) | (hit_ctrl & bad_ctrl));

  // RULE6: run forwarded only with a stable oscillator
  wire run_fwd = pwdata[SWT_RUN_BIT] & osc_stable;
  wire [7:0] ctl_word = {SWT_RSVD_ZERO, 1'b1, run_fwd, pwdata[SWT_PS_MSB:SWT_PS_LSB]};
  wire [7:0] fclr_word = {SWT_RSVD_ZERO, 1'b0, hctrl_r[SWT_RUN_BIT:SWT_PS_LSB]};
  wire fwd = rel_ok | ctl_ok | fclr;
  wire [7:0] fwd_addr = rel_ok ? SWT_ADDR_RELOAD : SWT_ADDR_CTRL;
  wire [7:0] fwd_data = rel_ok ? pwdata[7:0] : ctl_ok ? ctl_word : fclr_word;

  // Overflow seen as a rising flag in the polled control word
  wire ovf_evt = rd_d_r & bus.sfr_rdata[SWT_FLAG_BIT] & ~mirror_r[SWT_FLAG_BIT];
  wire [SWT_ST_W-1:0] set_mask = {refused, ovf_evt};
  wire [SWT_ST_W-1:0] clr_mask = (wr_take & hit_iclr) ? pwdata[SWT_ST_W-1:0] : '0;

  // APB answer one cycle after setup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else if (ce) begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= rd_word;
      end
    end
  end

  // Controller registers, status set wins over clear
  // RULE7: run may precede sleep
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hctrl_r <= '0;
      hreload_r <= SWT_RELOAD_RST;
      ien_r <= '0;
      stat_r <= '0;
    end else if (ce) begin
      if (ctl_ok) begin
        hctrl_r <= {pwdata[SWT_H_OSCEN_BIT:SWT_FLAG_BIT], run_fwd,
                    pwdata[SWT_PS_MSB:SWT_PS_LSB]};
      end
      if (rel_ok) begin
        hreload_r <= pwdata[7:0];
      end
      if (wr_take & hit_ien) begin
        ien_r <= pwdata[SWT_ST_W-1:0];
      end
      stat_r <= (stat_r & ~clr_mask) | set_mask;
    end
  end

  // Timer port: one write pulse per request, otherwise poll control
  // RULE13: software clears flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sfr_wr_r <= 1'b0;
      sfr_rd_r <= 1'b0;
      sfr_addr_r <= SWT_ADDR_CTRL;
      sfr_wdata_r <= 8'h00;
      rd_d_r <= 1'b0;
      mirror_r <= SWT_CTRL_RST;
      irq_r <= 1'b0;
    end else if (ce) begin
      sfr_wr_r <= fwd;
      sfr_rd_r <= ~fwd;
      sfr_addr_r <= fwd ? fwd_addr : SWT_ADDR_CTRL;
      sfr_wdata_r <= fwd ? fwd_data : 8'h00;
      rd_d_r <= sfr_rd_r;
      if (rd_d_r) begin
        mirror_r <= bus.sfr_rdata;
      end
      irq_r <= |(stat_r & ien_r);
    end
  end

  assign bus.sfr_wr = sfr_wr_r;
  assign bus.sfr_rd = sfr_rd_r;
  assign bus.sfr_addr = sfr_addr_r;
  assign bus.sfr_wdata = sfr_wdata_r;
  assign bus.wakeup_irq_enable = hctrl_r[SWT_H_WIEN_BIT];
  assign bus.global_irq_enable = hctrl_r[SWT_H_GIEN_BIT];
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign osc_enable = hctrl_r[SWT_H_OSCEN_BIT];

endmodule

// ===== sim/swt_sva.sv
// Purpose: Checks the register port between timer and controller
// Assumes: One clock, reset active low
// Notes: Helper flops track the last settings sent to the timer
`timescale 1ns/1ps
module swt_sva
  import swt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic wakeup_irq_enable,
  input wire logic global_irq_enable
);
  logic run_r;
  logic [2:0] ps_r;
  logic [7:0] rel_r;
  // Request decode
  wire rd_ctrl = sfr_rd && (sfr_addr == SWT_ADDR_CTRL);
  wire wr_ctrl = sfr_wr && (sfr_addr == SWT_ADDR_CTRL);
  wire wr_rel = sfr_wr && (sfr_addr == SWT_ADDR_RELOAD);
  wire both_en = wakeup_irq_enable && global_irq_enable;
  // Last run, prescale and reload sent
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
      ps_r <= SWT_PS_DIV1;
      rel_r <= SWT_RELOAD_RST;
    end else begin
      if (wr_ctrl) begin
        run_r <= sfr_wdata[SWT_RUN_BIT];
        ps_r <= sfr_wdata[SWT_PS_MSB:SWT_PS_LSB];
      end
      if (wr_rel) begin
        rel_r <= sfr_wdata;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  rst_zero_a: assert property ($rose(rstn) |-> sfr_rdata == SWT_CTRL_RST)
    else $error("read data not zero after reset");
  rsvd_zero_a: assert property (rd_ctrl |=> sfr_rdata[7:5] == SWT_RSVD_ZERO)
    else $error("reserved control bits not zero");
  ctrl_back_a: assert property (wr_ctrl ##1 rd_ctrl |=>
    sfr_rdata[3:0] == $past(sfr_wdata[3:0], 2)) else $error("control readback wrong");
  flag_hold_a: assert property (rd_ctrl ##1 (rd_ctrl && sfr_rdata[SWT_FLAG_BIT])
    |=> sfr_rdata[SWT_FLAG_BIT]) else $error("overflow flag dropped");
  reload_halt_a: assert property (wr_rel |-> !run_r)
    else $error("reload written while running");
  reload_ff_a: assert property (wr_rel && sfr_wdata == SWT_CNT_MAX |->
    ps_r != SWT_PS_DIV1) else $error("reload ff sent at divide by one");
  ps_div1_a: assert property (wr_ctrl && sfr_wdata[2:0] == SWT_PS_DIV1 |->
    rel_r != SWT_CNT_MAX) else $error("divide by one sent with reload ff");
  run_sent_a: assert property (wr_ctrl && sfr_wdata[SWT_RUN_BIT] |=>
    run_r && !sfr_wr) else $error("run setting not held");
  cover property (wr_rel);
  cover property (rd_ctrl ##1 sfr_rdata[SWT_FLAG_BIT]);
  cover property (wr_ctrl && both_en);
endmodule

// ===== sim/tb_self_wakeup_timer.sv
// Purpose: Drives the controller over APB and checks the timer through it
// Assumes: Oscillator run faster than nominal, still above twice per clock
// Notes: Model of the controller registers is kept in bench variables
`timescale 1ns/1ps
module tb_self_wakeup_timer;
  import swt_pkg::*;
  localparam int OSC_HALF = 4; // Clocks per oscillator phase, keeps run short
  logic clock, rstn, ce, osc_in, osc_stable, psel, penable, pwrite;
  logic pready, pslverr, irq, osc_enable, osc_keep_on, wake_irq, err_s;
  logic [7:0] paddr, m_rel;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] m_ctrl;
  logic [1:0] m_stat, m_ien;
  logic [15:0] seed;
  int bad_count, checked, cyc, t1;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  logic [2:0] ps_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic [7:0] rel_tab [4] = '{8'hfe, 8'hfc, 8'hfe, 8'hff};
  swt_if bus_if();
  swt_device swt_device_inst(.clock(clock), .rstn(rstn), .ce(ce), .osc_in(osc_in),
    .osc_keep_on(osc_keep_on), .wake_irq(wake_irq), .bus(bus_if));
  swt_host swt_host_inst(.clock(clock), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .osc_enable(osc_enable),
    .osc_stable(osc_stable), .bus(bus_if));
  swt_sva swt_sva_inst(.clock(clock), .rstn(rstn), .sfr_addr(bus_if.sfr_addr),
    .sfr_wr(bus_if.sfr_wr), .sfr_wdata(bus_if.sfr_wdata), .sfr_rd(bus_if.sfr_rd),
    .sfr_rdata(bus_if.sfr_rdata), .wakeup_irq_enable(bus_if.wakeup_irq_enable),
    .global_irq_enable(bus_if.global_irq_enable));
  // Clock, free oscillator and cycle count
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always begin
    repeat (OSC_HALF) @(posedge clock);
    osc_in <= ~osc_in;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // Hang guard
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    close_out;
  end
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [31:0] ex(input logic [7:0] a);
    case (a)
      SWT_APB_CTRL: return {25'h0, m_ctrl};
      SWT_APB_RELOAD: return {24'h0, m_rel};
      SWT_APB_STAT: return {30'h0, m_stat};
      SWT_APB_IEN: return {30'h0, m_ien};
      default: return 32'h0;
    endcase
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write and update the model, refused settings flag status bit 1
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      SWT_APB_CTRL: begin
        if (d[2:0] == 3'h0 && m_rel == 8'hff) m_stat[1] = 1'b1;
        else m_ctrl = {d[6:4], d[3] & osc_stable, d[2:0]};
      end
      SWT_APB_RELOAD: begin
        if (m_ctrl[3] || (d[7:0] == 8'hff && m_ctrl[2:0] == 3'h0)) m_stat[1] = 1'b1;
        else m_rel = d[7:0];
      end
      SWT_APB_IEN: m_ien = d[1:0];
      SWT_APB_ICLR: m_stat = m_stat & ~d[1:0];
      default: ;
    endcase
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task rdm;
    repeat (6) @(posedge clock);
    apb(1'b0, SWT_APB_MIRROR, 32'h0);
  endtask
  task wait_irq(input logic lvl);
    while (wake_irq !== lvl) @(posedge clock);
  endtask
  task close_out;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, osc_in, paddr, pwdata} = '0;
    {ce, osc_stable, m_ctrl, m_rel, m_stat, m_ien} = {2'b11, 19'h0};
    {seed, bad_count, checked, cyc} = {16'h2c76, 96'h0};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    foreach (rst_tab[i]) begin
      rd(rst_tab[i]);
      chk(q, ex(rst_tab[i]));
    end
    rd(8'h40);
    chk({q[30:0], err_s}, 32'h1);
    wr(SWT_APB_CTRL, 32'h87);
    rd(SWT_APB_CTRL);
    chk(q, ex(SWT_APB_CTRL));
    for (int i = 0; i < 8; i++) begin
      wr(SWT_APB_CTRL, i);
      rdm;
      chk(q & 32'hef, i);
    end
    repeat (4) begin
      seed = lfsr(seed);
      wr(SWT_APB_RELOAD, {24'h0, seed[7:0]});
      rd(SWT_APB_RELOAD);
      chk(q, ex(SWT_APB_RELOAD));
    end
    wr(SWT_APB_RELOAD, 32'hff);
    wr(SWT_APB_CTRL, 32'h0);
    rd(SWT_APB_STAT);
    chk(q, ex(SWT_APB_STAT));
    rd(SWT_APB_CTRL);
    chk(q, ex(SWT_APB_CTRL));
    wr(SWT_APB_ICLR, 32'h3);
    wr(SWT_APB_RELOAD, 32'h0);
    osc_stable <= 1'b0;
    wr(SWT_APB_CTRL, 32'h48);
    rdm;
    chk(q & 32'hef, 32'h0);
    chk(osc_enable, 1'b1);
    rd(SWT_APB_CTRL);
    chk(q, ex(SWT_APB_CTRL));
    osc_stable <= 1'b1;
    wr(SWT_APB_CTRL, 32'h78);
    rdm;
    chk(q & 32'hef, 32'h08);
    chk(osc_keep_on, 1'b1);
    wr(SWT_APB_RELOAD, 32'h10);
    rd(SWT_APB_STAT);
    chk(q & 32'h2, ex(SWT_APB_STAT) & 32'h2);
    rd(SWT_APB_RELOAD);
    chk(q, ex(SWT_APB_RELOAD));
    wr(SWT_APB_ICLR, 32'h3);
    foreach (ps_tab[i]) begin
      wr(SWT_APB_CTRL, 32'h77);
      wr(SWT_APB_RELOAD, {24'h0, rel_tab[i]});
      wr(SWT_APB_CTRL, 32'h78 | ps_tab[i]);
      wr(SWT_APB_FCLR, 32'h1);
      wait_irq(1'b0);
      wait_irq(1'b1);
      t1 = cyc;
      wr(SWT_APB_FCLR, 32'h1);
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk(cyc - t1, (256 - rel_tab[i]) * SWT_DIV[ps_tab[i]] * 2 * OSC_HALF);
    end
    m_stat[0] = 1'b1;
    wr(SWT_APB_CTRL, 32'h57);
    repeat (4) @(posedge clock);
    chk(wake_irq, 1'b0);
    wr(SWT_APB_CTRL, 32'h77);
    repeat (4) @(posedge clock);
    chk(wake_irq, 1'b1);
    rd(SWT_APB_STAT);
    chk(q, ex(SWT_APB_STAT));
    wr(SWT_APB_IEN, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    wr(SWT_APB_IEN, 32'h0);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    wr(SWT_APB_IEN, 32'h1);
    wr(SWT_APB_ICLR, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    rdm;
    chk(q & 32'h10, 32'h10);
    wr(SWT_APB_FCLR, 32'h1);
    rdm;
    chk(q & 32'h10, 32'h0);
    close_out;
  end
endmodule
